// ==== verilog/wdg_top.sv ====
/*
  watchdog timer: mode decode, clear sources, sleep handling, registers,
  interrupt status and reset/wake outputs.
  assumes all inputs synchronous to i_ref_clk; sleep, osc fail, start-up
  timer and status flag consumers live outside.
*/
// Design decisions made here: the register offsets and the strobed register port.
module wdg_top (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [wdg_pkg::ADDR_W-1:0] i_addr,
  input wire logic [wdg_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [wdg_pkg::DATA_W-1:0] o_rdata,
  output logic o_irq,
  input wire logic [1:0] i_wd_mode_cfg,
  input wire logic i_low_freq_internal_osc,
  input wire logic i_wd_clear_instruction,
  input wire logic i_sleep,
  input wire logic i_osc_fail,
  input wire logic i_osc_startup_timer,
  input wire logic i_sysclk_crystal,
  output logic o_dev_reset,
  output logic o_wake,
  output logic o_timeout_status_flag_n,
  output logic o_powerdown_status_flag_n,
  output logic o_wd_reset_cause_flag_n
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] wd_prescale_select;
    logic wd_soft_enable;
    logic [wdg_pkg::EVT_W-1:0] irq_stat;
    logic [wdg_pkg::EVT_W-1:0] irq_mask;
    logic [wdg_pkg::DATA_W-1:0] rdata;
    logic irq;
    logic dev_reset;
    logic wake;
    logic to_n;
    logic pd_n;
    logic rc_n;
    logic osc_prev;
    logic sleep_prev;
    logic tick;
    logic clear;
  } wdg_top_s;

  wdg_top_s st;
  wdg_top_s next_st;
  wdg_cnt_if cif ();

  logic active;
  logic sleep_edge;
  logic ost_hold;
  logic [wdg_pkg::EVT_W-1:0] evt;
  logic [wdg_pkg::DATA_W-1:0] flags;

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  assign cif.tick = st.tick;
  assign cif.clear = st.clear;
  assign cif.ratio_sel = st.wd_prescale_select;

  wdg_counter u_cnt (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .cif(cif)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    active = wdg_pkg::wdg_active(i_wd_mode_cfg, st.wd_soft_enable,
                                 i_sleep);
    sleep_edge = i_sleep != st.sleep_prev;
    // start-up hold only applies to crystal clocks; other clocks clear
    // once through the sleep edge alone
    ost_hold = i_osc_startup_timer && i_sysclk_crystal;
    evt = '0;
    flags = '0;

    // rising oscillator edge is the only time base, whatever the cpu clock
    next_st.osc_prev = i_low_freq_internal_osc;
    next_st.tick = i_low_freq_internal_osc && !st.osc_prev;
    next_st.sleep_prev = i_sleep;

    // divider changes are not a clear source, so the count carries on
    next_st.clear = i_wd_clear_instruction || sleep_edge || i_osc_fail
                    || !active || ost_hold;

    next_st.dev_reset = 1'b0;
    next_st.wake = 1'b0;
    if (i_wd_clear_instruction) begin
      next_st.to_n = 1'b1;
      next_st.pd_n = 1'b1;
    end
    if (i_sleep && !st.sleep_prev) begin
      next_st.to_n = 1'b1;
      next_st.pd_n = 1'b0;
    end
    if (cif.timeout) begin
      next_st.to_n = 1'b0;
      next_st.rc_n = 1'b0;
      if (i_sleep) begin
        next_st.wake = 1'b1;
        evt[wdg_pkg::EVT_WAKE_BIT] = 1'b1;
      end else begin
        next_st.dev_reset = 1'b1;
        evt[wdg_pkg::EVT_RESET_BIT] = 1'b1;
      end
    end

    // register writes
    if (i_wr) begin
      case (i_addr)
        wdg_pkg::ADR_CTRL: begin
          next_st.wd_prescale_select =
            i_wdata[wdg_pkg::CTRL_PS_MSB:wdg_pkg::CTRL_PS_LSB];
          next_st.wd_soft_enable = i_wdata[wdg_pkg::CTRL_EN_BIT];
        end
        wdg_pkg::ADR_IRQ_STAT: begin
          next_st.irq_stat = st.irq_stat & ~i_wdata[wdg_pkg::EVT_W-1:0];
        end
        wdg_pkg::ADR_IRQ_MASK: begin
          next_st.irq_mask = i_wdata[wdg_pkg::EVT_W-1:0];
        end
        wdg_pkg::ADR_FLAGS: begin
          if (i_wdata[wdg_pkg::FLG_RC_BIT] && !cif.timeout) begin
            next_st.rc_n = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // a new event beats a same-cycle write-one-to-clear
    next_st.irq_stat = next_st.irq_stat | evt;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);

    // register reads, data in the following cycle only
    flags[wdg_pkg::FLG_TO_BIT] = st.to_n;
    flags[wdg_pkg::FLG_PD_BIT] = st.pd_n;
    flags[wdg_pkg::FLG_RC_BIT] = st.rc_n;
    flags[wdg_pkg::FLG_MODE_LSB +: 2] = i_wd_mode_cfg;
    next_st.rdata = '0;
    if (i_rd) begin
      case (i_addr)
        wdg_pkg::ADR_CTRL: begin
          // top two bits stay zero, they are not implemented
          next_st.rdata[wdg_pkg::CTRL_PS_MSB:wdg_pkg::CTRL_PS_LSB] =
            st.wd_prescale_select;
          next_st.rdata[wdg_pkg::CTRL_EN_BIT] = st.wd_soft_enable;
        end
        wdg_pkg::ADR_IRQ_STAT: begin
          next_st.rdata[wdg_pkg::EVT_W-1:0] = st.irq_stat;
        end
        wdg_pkg::ADR_IRQ_MASK: begin
          next_st.rdata[wdg_pkg::EVT_W-1:0] = st.irq_mask;
        end
        wdg_pkg::ADR_FLAGS: begin
          next_st.rdata = flags;
        end
        default: begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
      st.wd_prescale_select <= wdg_pkg::PS_RESET;
      st.to_n <= 1'b1;
      st.pd_n <= 1'b1;
      st.rc_n <= 1'b1;
      st.clear <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_irq = st.irq;
  assign o_dev_reset = st.dev_reset;
  assign o_wake = st.wake;
  assign o_timeout_status_flag_n = st.to_n;
  assign o_powerdown_status_flag_n = st.pd_n;
  assign o_wd_reset_cause_flag_n = st.rc_n;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  AST_AWAKE_RESET: assert property (
    (cif.timeout && !i_sleep) |=> (o_dev_reset && !o_wake
                                   && !o_wd_reset_cause_flag_n))
    else $error("awake time-out gave no device reset");
  AST_SLEEP_WAKE: assert property (
    (cif.timeout && i_sleep) |=> (o_wake && !o_dev_reset
                                  && !o_timeout_status_flag_n))
    else $error("sleep time-out did not wake cleanly");
  AST_MODE_OFF: assert property (
    (i_wd_mode_cfg == wdg_pkg::WDG_MODE_OFF) |=> st.clear ##1 !o_dev_reset)
    else $error("mode off let the count run");
  AST_MODE_ON: assert property (
    (i_wd_mode_cfg == wdg_pkg::WDG_MODE_ON && !sleep_edge
     && !i_wd_clear_instruction && !i_osc_fail && !ost_hold) |=> !st.clear)
    else $error("always-on mode was cleared");
  AST_MODE_NOSLEEP: assert property (
    (i_wd_mode_cfg == wdg_pkg::WDG_MODE_NOSLEEP && i_sleep) |=> st.clear)
    else $error("sleep did not disable the count");
  AST_MODE_SOFT: assert property (
    (i_wd_mode_cfg == wdg_pkg::WDG_MODE_SOFT && !st.wd_soft_enable)
    |=> st.clear)
    else $error("soft disable did not clear");
  AST_CLEAR_SRC: assert property (
    (i_wd_clear_instruction || i_osc_fail || sleep_edge) |=> st.clear)
    else $error("clear source ignored");
  AST_OST_HOLD: assert property (
    (i_osc_startup_timer && i_sysclk_crystal) [*2] |=> st.clear)
    else $error("start-up hold released early");
  AST_CTRL_WRITE: assert property (
    (i_wr && i_addr == wdg_pkg::ADR_CTRL) |=>
    (st.wd_prescale_select == $past(i_wdata[5:1])
     && st.wd_soft_enable == $past(i_wdata[0])))
    else $error("control write not stored");
  AST_CTRL_READ: assert property (
    (i_rd && i_addr == wdg_pkg::ADR_CTRL) |=>
    (o_rdata[7:6] == 2'b00 && o_rdata[5:1] == $past(st.wd_prescale_select)))
    else $error("control read wrong");
endmodule : wdg_top

// ==== inc/wdg_pkg.sv ====
/*
  constants, types and helpers of the watchdog timer.
  assumes one 200 MHz clock and a low-frequency oscillator level input.
*/
// Function
// - awake time-out without clear instruction resets the device.
// - time base is the independent low-frequency oscillator, 1 ms base interval.
// - mode 00 keeps the watchdog disabled always.
// - mode 11 keeps it active always, soft enable ignored.
// - mode 10 is active awake and disabled in sleep.
// - mode 01 follows the soft enable bit, sleep has no effect.
// - prescale select sets 1 ms to 256 s, two seconds after reset.
// - count clears on reset, clear instruction, sleep edges, osc fail, disable, start-up.
// - sleep entry clears; if still enabled, counting restarts from zero.
// - sleep exit on crystal clock holds clear until start-up timer ends.
// - sleep exit on RC, internal or external clock clears once only.
// - sleep time-out wakes the device, updates status and reset-cause flags.
// - oscillator divider changes leave the count untouched.
// - prescale code 0 is 1:32, doubling to 10010; higher codes act as 1:32.
// - prescale in bits 5..1, enable bit 0, bits 7..6 read zero.
package wdg_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int CNT_W = 24;
  localparam logic [ADDR_W-1:0] ADR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADR_IRQ_STAT = 4'h1;
  localparam logic [ADDR_W-1:0] ADR_IRQ_MASK = 4'h2;
  localparam logic [ADDR_W-1:0] ADR_FLAGS = 4'h3;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PS_LSB = 1;
  localparam int CTRL_PS_MSB = 5;
  localparam int FLG_TO_BIT = 0;
  localparam int FLG_PD_BIT = 1;
  localparam int FLG_RC_BIT = 2;
  localparam int FLG_MODE_LSB = 3;
  localparam int EVT_RESET_BIT = 0;
  localparam int EVT_WAKE_BIT = 1;
  localparam int EVT_W = 2;
  localparam logic [4:0] PS_RESET = 5'h0B;
  localparam logic [4:0] PS_MAX = 5'h12;
  localparam logic [4:0] RATIO_LOG2_MIN = 5'h05;
  localparam int LFOSC_KHZ = 31;
  localparam int BASE_INTERVAL_MS = 1;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h00_0001;

  typedef enum logic [1:0] {
    WDG_MODE_OFF = 2'b00,
    WDG_MODE_SOFT = 2'b01,
    WDG_MODE_NOSLEEP = 2'b10,
    WDG_MODE_ON = 2'b11
  } wdg_mode_e;

  // 1:32 at code 0, doubling per step; reserved codes fall back to 1:32
  function automatic logic [4:0] wdg_ratio_log2(input logic [4:0] sel);
    if (sel > PS_MAX) begin
      wdg_ratio_log2 = RATIO_LOG2_MIN;
    end else begin
      wdg_ratio_log2 = sel + RATIO_LOG2_MIN;
    end
  endfunction : wdg_ratio_log2

  function automatic logic wdg_active(input logic [1:0] mode,
                                      input logic en, input logic asleep);
    case (mode)
      WDG_MODE_ON: wdg_active = 1'b1;
      WDG_MODE_NOSLEEP: wdg_active = !asleep;
      WDG_MODE_SOFT: wdg_active = en;
      default: wdg_active = 1'b0;
    endcase
  endfunction : wdg_active
endpackage : wdg_pkg

// ==== inc/wdg_cnt_if.sv ====
/*
  link between watchdog control and its tick counter.
  assumes both ends share one clock.
*/
interface wdg_cnt_if;
  logic tick;
  logic clear;
  logic [4:0] ratio_sel;
  logic timeout;
  modport ctl (output tick, output clear, output ratio_sel, input timeout);
  modport cnt (input tick, input clear, input ratio_sel, output timeout);
endinterface : wdg_cnt_if

// ==== verilog/wdg_counter.sv ====
/*
  oscillator tick counter with ratio compare, one-cycle time-out pulse.
  assumes tick and clear are registered by the controller.
*/
module wdg_counter (
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  wdg_cnt_if.cnt cif
);
  typedef struct packed {
    logic [wdg_pkg::CNT_W-1:0] cnt;
    logic timeout;
  } wdg_cnt_s;

  wdg_cnt_s st;
  wdg_cnt_s next_st;
  logic [wdg_pkg::CNT_W-1:0] last;

  always_comb begin
    last = (wdg_pkg::CNT_ONE << wdg_pkg::wdg_ratio_log2(cif.ratio_sel))
           - wdg_pkg::CNT_ONE;
    next_st = st;
    next_st.timeout = 1'b0;
    if (cif.clear) begin
      next_st.cnt = '0;
    end else if (cif.tick) begin
      if (st.cnt >= last) begin
        // >= so a smaller ratio picked mid-count still expires
        next_st.cnt = '0;
        next_st.timeout = 1'b1;
      end else begin
        next_st.cnt = st.cnt + wdg_pkg::CNT_ONE;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cif.timeout = st.timeout;

  AST_CNT_EXPIRE: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (cif.tick && !cif.clear && st.cnt == last) |=> (st.timeout && st.cnt == 0))
    else $error("count did not expire at selected ratio");
  AST_CNT_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    cif.clear |=> (st.cnt == 0 && !st.timeout))
    else $error("clear did not zero the count");
endmodule : wdg_counter

// ==== testbench/test_wdg_top.sv ====
/*
  self-checking bench of the watchdog timer top.
  assumes the bench alone drives every input; the oscillator is a slow
  square wave made from the reference clock.
*/
module test_wdg_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic i_ref_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [wdg_pkg::ADDR_W-1:0] i_addr = '0;
  logic [wdg_pkg::DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [wdg_pkg::DATA_W-1:0] o_rdata;
  logic o_irq, o_dev_reset, o_wake;
  logic [1:0] i_wd_mode_cfg = 2'b00;
  logic osc = 1'b0;
  logic clr = 1'b0;
  logic i_sleep = 1'b0;
  logic fail = 1'b0;
  logic osc_startup_timer = 1'b0;
  logic xtal = 1'b0;
  logic to_n, pd_n, rc_n;
  logic [7:0] rdv;
  int mismatches = 0;
  int checks = 0;
  int n_rst = 0;
  int n_wake = 0;
  int cyc = 0;

  wdg_top wdg_top_inst (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .i_wd_mode_cfg(i_wd_mode_cfg),
    .i_low_freq_internal_osc(osc), .i_wd_clear_instruction(clr),
    .i_sleep(i_sleep), .i_osc_fail(fail), .i_osc_startup_timer(osc_startup_timer),
    .i_sysclk_crystal(xtal), .o_dev_reset(o_dev_reset), .o_wake(o_wake),
    .o_timeout_status_flag_n(to_n), .o_powerdown_status_flag_n(pd_n),
    .o_wd_reset_cause_flag_n(rc_n)
  );

  initial begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  // pulses are one cycle, so count them at every edge
  always @(posedge i_ref_clk) begin
    if (o_dev_reset === 1'b1) n_rst <= n_rst + 1;
    if (o_wake === 1'b1) n_wake <= n_wake + 1;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 rdv = o_rdata;
  endtask : rd

  task automatic pulse_clr();
    @(posedge i_ref_clk);
    clr <= 1'b1;
    @(posedge i_ref_clk);
    clr <= 1'b0;
  endtask : pulse_clr

  // n oscillator ticks, then the reset and wake pulses seen meanwhile
  task automatic run(input int n, input int er, input int ew);
    int br, bw;
    br = n_rst;
    bw = n_wake;
    repeat (n) begin
      @(posedge i_ref_clk);
      osc <= 1'b1;
      repeat (2) @(posedge i_ref_clk);
      osc <= 1'b0;
      repeat (2) @(posedge i_ref_clk);
    end
    repeat (4) @(posedge i_ref_clk);
    #1;
    chk("reset pulses", 8'(er), 8'(n_rst - br));
    chk("wake pulses", 8'(ew), 8'(n_wake - bw));
  endtask : run

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(wdg_pkg::ADR_CTRL);
    chk("ctrl reset", {2'b00, wdg_pkg::PS_RESET, 1'b0}, rdv);
    rd(wdg_pkg::ADR_FLAGS);
    chk("flags reset", 8'h07, rdv);
    wr(wdg_pkg::ADR_CTRL, 8'hFF);
    rd(wdg_pkg::ADR_CTRL);
    chk("ctrl top bits", 8'h3F, rdv);
    wr(4'h7, 8'hFF);
    rd(4'h7);
    chk("unmapped", 8'h00, rdv);
    $display("test regs done");
  endtask : t_regs

  task automatic t_awake();
    i_wd_mode_cfg <= 2'b11;
    wr(wdg_pkg::ADR_CTRL, 8'h00);
    wr(wdg_pkg::ADR_IRQ_MASK, 8'h01);
    pulse_clr();
    run(31, 0, 0);
    pulse_clr();
    run(31, 0, 0);
    run(1, 1, 0);
    chk("irq", 8'h01, {7'h0, o_irq});
    chk("cause flag pin", 8'h00, {7'h0, rc_n});
    rd(wdg_pkg::ADR_FLAGS);
    chk("flags after reset", 8'h1A, rdv);
    rd(wdg_pkg::ADR_IRQ_STAT);
    chk("irq status", 8'h01, rdv);
    rd(wdg_pkg::ADR_IRQ_MASK);
    chk("irq mask", 8'h01, rdv);
    wr(wdg_pkg::ADR_IRQ_STAT, 8'h01);
    wr(wdg_pkg::ADR_FLAGS, 8'h04);
    rd(wdg_pkg::ADR_FLAGS);
    chk("cause restored", 8'h1E, rdv);
    chk("cause pin restored", 8'h01, {7'h0, rc_n});
    rd(wdg_pkg::ADR_IRQ_STAT);
    chk("irq status cleared", 8'h00, rdv);
    chk("irq cleared", 8'h00, {7'h0, o_irq});
    $display("test awake done");
  endtask : t_awake

  task automatic t_modes();
    bit act;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        act = (m == 3) || (m == 2 && k[1] == 0) || (m == 1 && k[0] == 1);
        i_wd_mode_cfg <= 2'(m);
        i_sleep <= k[1];
        wr(wdg_pkg::ADR_CTRL, {7'h0, k[0]});
        pulse_clr();
        run(32, act && !k[1], act && k[1]);
        chk("timeout flag", {7'h0, !act}, {7'h0, to_n});
      end
    end
    i_sleep <= 1'b0;
    $display("test modes done");
  endtask : t_modes

  task automatic t_prescale();
    logic [4:0] code [3] = '{5'h01, 5'h13, 5'h1F};
    int ratio [3] = '{64, 32, 32};
    i_wd_mode_cfg <= 2'b11;
    for (int i = 0; i < 3; i++) begin
      wr(wdg_pkg::ADR_CTRL, {2'b00, code[i], 1'b0});
      pulse_clr();
      run(ratio[i] - 1, 0, 0);
      run(1, 1, 0);
    end
    wr(wdg_pkg::ADR_CTRL, 8'h00);
    $display("test prescale done");
  endtask : t_prescale

  task automatic t_sleep();
    pulse_clr();
    i_sleep <= 1'b1;
    run(31, 0, 0);
    chk("powerdown flag", 8'h00, {7'h0, pd_n});
    xtal <= 1'b1;
    osc_startup_timer <= 1'b1;
    i_sleep <= 1'b0;
    run(40, 0, 0);
    osc_startup_timer <= 1'b0;
    run(31, 0, 0);
    run(1, 1, 0);
    // startup timer still running, but a non-crystal clock ignores it
    xtal <= 1'b0;
    osc_startup_timer <= 1'b1;
    i_sleep <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    i_sleep <= 1'b0;
    run(31, 0, 0);
    run(1, 1, 0);
    run(20, 0, 0);
    @(posedge i_ref_clk);
    fail <= 1'b1;
    @(posedge i_ref_clk);
    fail <= 1'b0;
    run(31, 0, 0);
    run(1, 1, 0);
    osc_startup_timer <= 1'b0;
    $display("test sleep done");
  endtask : t_sleep

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    t_regs();
    t_awake();
    t_modes();
    t_prescale();
    t_sleep();
    end_of_test();
  end
endmodule : test_wdg_top
